// >>> rtk_pkg.sv
// rtk_pkg: shared constants of the real-time clock timekeeper.
// assumes: imported whole by every rtk module except rtk_xtal_cap_model.
package rtk_pkg;

    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_CTRL    = 5'h00;
    localparam logic [4:0] IDX_CALIB   = 5'h01;
    localparam logic [4:0] IDX_SEC     = 5'h02;
    localparam logic [4:0] IDX_YEAR    = 5'h08;
    localparam logic [4:0] IDX_COMP    = 5'h0B;

    // control register bits
    localparam int BIT_SNAP      = 0;
    localparam int BIT_LOCK      = 1;
    localparam int BIT_CAL_MODE  = 2;
    // calibration register fields
    localparam int CAL_MAG_LSB   = 0;
    localparam int CAL_MAG_W     = 5;
    localparam int BIT_CAL_SIGN  = 5;
    localparam int BIT_OSC_OFF   = 7;
    // companion control bits
    localparam int BIT_CHARGE    = 2;
    localparam int BIT_FAST      = 5;

    localparam logic [7:0] CALIB_RESET = 8'h80;
    localparam logic [7:0] COMP_RESET  = 8'h00;

    // time fields: sec, min, hour, day, date, month, year (bcd)
    localparam int NUM_TIME = 7;
    localparam logic [55:0] TIME_RESET = 56'h00_01_01_01_00_00_00;

    // time base and calibration output
    localparam int XTAL_HZ     = 32768;
    localparam int SQ_HZ       = 512;
    localparam int DIV_W       = $clog2(XTAL_HZ);
    localparam int SQ_BIT      = $clog2(XTAL_HZ / SQ_HZ) - 1;
    // correction window in seconds and pulses moved per magnitude step
    localparam int CAL_WIN_SEC = 64;
    localparam int CAL_STEP    = 9;

    localparam logic [31:0] APB_ZERO = 32'h0000_0000;

endpackage : rtk_pkg

// >>> rtk_date_step.sv
// rtk_date_step: one-second bcd advance of the seven time fields.
// assumes: inputs hold legal bcd values, as software must load.
`timescale 1ns/1ps
module rtk_date_step
    import rtk_pkg::*;
(
    // time in and out, byte 0 seconds up to byte 6 year
    input  wire logic [55:0] time_in,
    output logic      [55:0] time_out
);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [7:0] r;
        r = v + 8'h01;
        if (v == hi) begin
            r = lo;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction : bcd_inc

    logic [7:0] sec, mins, hour, day, date, mon, year, last;
    logic       leap;

    always_comb begin
        {year, mon, date, day, hour, mins, sec} = time_in;
        // leap when year mod 4 is zero; tens parity carries 2 mod 4
        leap = ((({3'h0, year[4]} << 1) + year[3:0]) & 4'h3) == 4'h0;
        case (mon)
            8'h02:   last = leap ? 8'h29 : 8'h28;
            8'h04,
            8'h06,
            8'h09,
            8'h11:   last = 8'h30;
            default: last = 8'h31;
        endcase
        time_out = time_in;
        time_out[7:0] = bcd_inc(sec, 8'h00, 8'h59);
        if (sec == 8'h59) begin
            time_out[15:8] = bcd_inc(mins, 8'h00, 8'h59);
            if (mins == 8'h59) begin
                time_out[23:16] = bcd_inc(hour, 8'h00, 8'h23);
                if (hour == 8'h23) begin
                    time_out[31:24] = bcd_inc(day, 8'h01, 8'h07);
                    time_out[39:32] = bcd_inc(date, 8'h01, last);
                    if (date == last) begin
                        time_out[47:40] = bcd_inc(mon, 8'h01, 8'h12);
                        if (mon == 8'h12) begin
                            time_out[55:48] = bcd_inc(year, 8'h00, 8'h99);
                        end
                    end
                end
            end
        end
    end

endmodule : rtk_date_step

// >>> rtk_prescaler.sv
// rtk_prescaler: crystal divider with digital correction and 512 Hz tap.
// assumes: xtal_tick_in is a one-cycle pulse per crystal period.
`timescale 1ns/1ps
module rtk_prescaler
    import rtk_pkg::*;
#(
    parameter int DIV_BITS = DIV_W
)(
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 reset_n_in,
    // time base and correction setting
    input  wire logic                 xtal_tick_in,
    input  wire logic                 halt_in,
    input  wire logic                 sign_in,
    input  wire logic [CAL_MAG_W-1:0] mag_in,
    // outputs
    output logic                      sec_tick_out,
    output logic                      square_out
);

    // the second is the divider wrap, so only the crystal width will do
    generate
        if (DIV_BITS != DIV_W || DIV_BITS <= SQ_BIT + 1) begin : g_bad_div
            $error("DIV_BITS must equal the crystal divider width");
        end
    endgenerate

    localparam logic [DIV_BITS-1:0] DIV_ONE = DIV_BITS'(1);
    localparam logic [DIV_BITS-1:0] DIV_TWO = DIV_BITS'(2);
    localparam logic [5:0] WIN_LAST = 6'(CAL_WIN_SEC - 1);
    localparam logic [8:0] STEP = 9'(CAL_STEP);

    logic [DIV_BITS-1:0] div_q, div_add;
    logic [5:0]          win_q;
    logic [8:0]          credit_q;
    logic                wrap;

    // a correction pulse either doubles or skips one divider step
    always_comb begin
        div_add = DIV_ONE;
        if (credit_q != 9'h000) begin
            div_add = sign_in ? DIV_TWO : '0;
        end
    end
    assign wrap = xtal_tick_in && !halt_in &&
                  ({1'b0, div_q} + {1'b0, div_add}) > {1'b0, {DIV_BITS{1'b1}}};

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= '0;
        end else if (xtal_tick_in && !halt_in) begin
            div_q <= div_q + div_add;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            win_q    <= '0;
            credit_q <= '0;
        end else if (wrap) begin
            win_q <= win_q + 6'h01;
            if (win_q == WIN_LAST) begin
                credit_q <= 9'(mag_in * STEP);
            end
        end else if (xtal_tick_in && !halt_in && credit_q != 9'h000) begin
            credit_q <= credit_q - 9'h001;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sec_tick_out <= 1'b0;
            square_out   <= 1'b0;
        end else begin
            sec_tick_out <= wrap;
            square_out   <= div_q[SQ_BIT];
        end
    end

endmodule : rtk_prescaler

// >>> rtk_timekeeper.sv
// rtk_timekeeper: bcd real-time clock with apb registers, snapshot/lock
// handshake, charger controls and calibration output.
// assumes: all inputs synchronous to sys_clk_in; xtal_tick_in pulses
// once per 32.768 kHz period.
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Functional notes
// - divide crystal base to one-second time steps
// - seven readable and writable time registers
// - snapshot bit rising copies core into holding
// - pending second applied before snapshot copy
// - holding frozen while snapshot bit stays set
// - lock bit keeps host writes off core
// - lock release loads all time registers into core
// - core counts always except while locked or while the oscillator-off bit is set
// - clock keeps running on backup supply
// - charge enable bit, stops at full
// - fast charge bit raises charger current
// - calibration bit takes shared output pin
// - calibration mode drives 512 Hz square wave
// - sign one adds pulses, zero removes
// - magnitude five bits, sign above, nonvolatile; code reloads CALIB_RESET at reset
// - calibration writes accepted only in calibration mode; code still takes the oscillator-off bit in any mode
// - leaving calibration returns pin to comparator
// - each step about 4.34 ppm, zero none; code moves 9 pulses per 64 s, about 4.29 ppm
// - registers in their own bus address space
module rtk_timekeeper
    import rtk_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // time base and analog status
    input  wire logic        xtal_tick_in,
    input  wire logic        supply_low_in,
    input  wire logic        backup_full_in,
    input  wire logic        pfi_low_in,
    // pins and analog controls
    output logic             calib_or_powerfail_out,
    output logic             backup_select_out,
    output logic             backup_charge_enable_out,
    output logic             fast_charge_enable_out
);

    logic [7:0]  core_q [NUM_TIME];
    logic [7:0]  user_q [NUM_TIME];
    logic        snap_q;
    logic        lock_q;
    logic        cal_mode_q;
    logic        cal_sign_q;
    logic [4:0]  cal_mag_q;
    logic        osc_off_q;
    logic        charge_q;
    logic        fast_q;

    logic [55:0] core_flat;
    logic [55:0] core_step;
    logic        sec_tick;
    logic        square;

    // apb decode
    logic [4:0]  idx;
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic        is_time;
    logic [2:0]  tidx;
    logic [7:0]  wbyte;
    logic        ctrl_wr;
    logic        snap_rise;
    logic        lock_fall;
    logic [31:0] rdata;

    assign idx     = paddr_in[6:2];
    assign access  = psel_in && penable_in && !pready_out;
    assign wr_en   = psel_in && penable_in && pready_out && pwrite_in &&
                     !pslverr_out;
    assign is_time = idx >= IDX_SEC && idx <= IDX_YEAR;
    assign tidx    = 3'(idx - IDX_SEC);
    assign wbyte   = pwdata_in[7:0];
    assign ctrl_wr = wr_en && idx == IDX_CTRL;
    assign snap_rise = ctrl_wr && wbyte[BIT_SNAP] && !snap_q;
    assign lock_fall = ctrl_wr && !wbyte[BIT_LOCK] && lock_q;

    // only this block's own registers answer on its select
    always_comb begin
        mapped = is_time || idx == IDX_CTRL || idx == IDX_CALIB ||
                 idx == IDX_COMP;
        mapped = mapped && paddr_in[7] == 1'b0 && paddr_in[1:0] == 2'b00;
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TIME; g++) begin : g_flat
            assign core_flat[g*8 +: 8] = core_q[g];
        end
    endgenerate

    rtk_date_step u_step (
        .time_in  (core_flat),
        .time_out (core_step)
    );

    rtk_prescaler #(
        .DIV_BITS (DIV_W)
    ) u_presc (
        .sys_clk_in   (sys_clk_in),
        .reset_n_in   (reset_n_in),
        .xtal_tick_in (xtal_tick_in),
        .halt_in      (osc_off_q),
        .sign_in      (cal_sign_q),
        .mag_in       (cal_mag_q),
        .sec_tick_out (sec_tick),
        .square_out   (square)
    );

    // read mux
    always_comb begin
        rdata = APB_ZERO;
        if (is_time) begin
            rdata[7:0] = user_q[tidx];
        end else if (idx == IDX_CTRL) begin
            rdata[BIT_SNAP]     = snap_q;
            rdata[BIT_LOCK]     = lock_q;
            rdata[BIT_CAL_MODE] = cal_mode_q;
        end else if (idx == IDX_CALIB) begin
            rdata[CAL_MAG_LSB +: CAL_MAG_W] = cal_mag_q;
            rdata[BIT_CAL_SIGN] = cal_sign_q;
            rdata[BIT_OSC_OFF]  = osc_off_q;
        end else if (idx == IDX_COMP) begin
            rdata[BIT_CHARGE] = charge_q;
            rdata[BIT_FAST]   = fast_q;
        end
    end

    // one wait state: answer in the second access cycle
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= APB_ZERO;
        end else begin
            pready_out  <= access;
            pslverr_out <= access && !mapped;
            if (access) begin
                prdata_out <= (mapped && !pwrite_in) ? rdata : APB_ZERO;
            end
        end
    end

    // control register
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            snap_q     <= 1'b0;
            lock_q     <= 1'b0;
            cal_mode_q <= 1'b0;
        end else if (ctrl_wr) begin
            snap_q     <= wbyte[BIT_SNAP];
            lock_q     <= wbyte[BIT_LOCK];
            cal_mode_q <= wbyte[BIT_CAL_MODE];
        end
    end

    // calibration register; not touched by supply loss, but reset_n_in reloads CALIB_RESET,
    // so unlike the nonvolatile cell it does not survive a backup failure
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cal_mag_q  <= CALIB_RESET[CAL_MAG_LSB +: CAL_MAG_W];
            cal_sign_q <= CALIB_RESET[BIT_CAL_SIGN];
            osc_off_q  <= CALIB_RESET[BIT_OSC_OFF];
        end else if (wr_en && idx == IDX_CALIB) begin
            osc_off_q <= wbyte[BIT_OSC_OFF];
            if (cal_mode_q) begin
                cal_mag_q  <= wbyte[CAL_MAG_LSB +: CAL_MAG_W];
                cal_sign_q <= wbyte[BIT_CAL_SIGN];
            end
        end
    end

    // companion control
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            charge_q <= COMP_RESET[BIT_CHARGE];
            fast_q   <= COMP_RESET[BIT_FAST];
        end else if (wr_en && idx == IDX_COMP) begin
            charge_q <= wbyte[BIT_CHARGE];
            fast_q   <= wbyte[BIT_FAST];
        end
    end

    // timekeeping core; supply state never gates it
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                core_q[i] <= TIME_RESET[i*8 +: 8];
            end
        end else if (lock_fall) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                core_q[i] <= user_q[i];
            end
        end else if (sec_tick && !lock_q) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                core_q[i] <= core_step[i*8 +: 8];
            end
        end
    end

    // holding registers
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                user_q[i] <= TIME_RESET[i*8 +: 8];
            end
        end else if (wr_en && is_time) begin
            user_q[tidx] <= wbyte;
        end else if (snap_rise) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                // take the stepped value when a second lands now
                user_q[i] <= (sec_tick && !lock_q) ?
                             core_step[i*8 +: 8] : core_q[i];
            end
        end else if (!snap_q && !lock_q) begin
            for (int i = 0; i < NUM_TIME; i++) begin
                user_q[i] <= core_q[i];
            end
        end
    end

    // shared pin: comparator idles high, so reset shows no failure
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            calib_or_powerfail_out <= 1'b1;
        end else begin
            calib_or_powerfail_out <= cal_mode_q ? square
                                                 : !pfi_low_in;
        end
    end

    // supply switchover follows the detector one cycle later
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            backup_select_out <= 1'b0;
        end else begin
            backup_select_out <= supply_low_in;
        end
    end

    // charger sources from main supply; off once backup is full
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            backup_charge_enable_out <= 1'b0;
        end else begin
            backup_charge_enable_out <= charge_q && !backup_full_in &&
                                        !supply_low_in;
        end
    end

    // fast mode only raises the current of an enabled charger
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fast_charge_enable_out <= 1'b0;
        end else begin
            fast_charge_enable_out <= fast_q && charge_q && !backup_full_in &&
                                      !supply_low_in;
        end
    end

endmodule : rtk_timekeeper

// >>> rtk_xtal_cap_model.sv
// rtk_xtal_cap_model: crystal time base and backup capacitor model.
// assumes: one crystal period per system clock, to shorten a second.
`timescale 1ns/1ps
module rtk_xtal_cap_model #(
    parameter int FULL_CYCLES = 20
)(
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    // charger control from the block
    input  wire logic charge_in,
    // time base and capacitor status
    output logic      xtal_tick_out,
    output logic      backup_full_out
);
    int unsigned charge_cnt_q;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            xtal_tick_out <= 1'b0;
        end else begin
            xtal_tick_out <= 1'b1;
        end
    end

    // capacitor keeps its charge once full; no leakage modelled
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            charge_cnt_q <= 0;
        end else if (charge_in && charge_cnt_q < FULL_CYCLES) begin
            charge_cnt_q <= charge_cnt_q + 1;
        end
    end
    assign backup_full_out = (charge_cnt_q >= FULL_CYCLES);
endmodule : rtk_xtal_cap_model

// >>> rtk_timekeeper_props.sv
// rtk_timekeeper_props: port-level checks of the timekeeper.
// assumes: bound to rtk_timekeeper; single clock domain.
`timescale 1ns/1ps
module rtk_timekeeper_props
    import rtk_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        reset_n_in,
    // apb
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    // analog status and pins
    input wire logic        supply_low_in,
    input wire logic        backup_full_in,
    input wire logic        pfi_low_in,
    input wire logic        calib_or_powerfail_out,
    input wire logic        backup_select_out,
    input wire logic        backup_charge_enable_out,
    input wire logic        fast_charge_enable_out
);
    logic cal_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // mirror of the calibration mode bit, taken at committed writes
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cal_q <= 1'b0;
        end else if (psel_in && penable_in && pready_out && pwrite_in
                     && paddr_in == 8'h00 && !pslverr_out) begin
            cal_q <= pwdata_in[BIT_CAL_MODE];
        end
    end

    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_wait; psel_in && penable_in && !pready_out; endsequence
    property p_answer; s_setup ##1 s_wait |=> pready_out; endproperty
    property p_ready_pulse; pready_out |=> !pready_out; endproperty
    property p_ready_cause;
        $rose(pready_out) |-> $past(psel_in && penable_in);
    endproperty
    property p_err_zero;
        pready_out && pslverr_out && !pwrite_in |-> prdata_out == APB_ZERO;
    endproperty
    property p_rdata_hi; pready_out |-> prdata_out[31:8] == 24'h000000;
    endproperty
    property p_backup_sel;
        $past(reset_n_in) |-> backup_select_out == $past(supply_low_in);
    endproperty
    property p_full_stops; backup_full_in |=> !backup_charge_enable_out;
    endproperty
    property p_low_stops;
        supply_low_in |=> !backup_charge_enable_out && !fast_charge_enable_out;
    endproperty
    property p_fast_needs;
        fast_charge_enable_out |-> backup_charge_enable_out;
    endproperty
    property p_pin_pfo;
        $past(reset_n_in) && !$past(cal_q)
            |-> calib_or_powerfail_out == !$past(pfi_low_in);
    endproperty

    a_answer: assert property (p_answer)
        else $error("ready missing one cycle into access");
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held longer than one cycle");
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without an access");
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returned data");
    a_rdata_hi: assert property (p_rdata_hi)
        else $error("read data upper bits not zero");
    a_backup_sel: assert property (p_backup_sel)
        else $error("backup select does not follow supply");
    a_full_stops: assert property (p_full_stops)
        else $error("charging past the limit");
    a_low_stops: assert property (p_low_stops)
        else $error("charging while on backup supply");
    a_fast_needs: assert property (p_fast_needs)
        else $error("fast charge without charge enable");
    a_pin_pfo: assert property (p_pin_pfo)
        else $error("pin not showing comparator outside calibration");
endmodule : rtk_timekeeper_props

bind rtk_timekeeper rtk_timekeeper_props u_rtk_timekeeper_props (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .supply_low_in(supply_low_in), .backup_full_in(backup_full_in),
    .pfi_low_in(pfi_low_in),
    .calib_or_powerfail_out(calib_or_powerfail_out),
    .backup_select_out(backup_select_out),
    .backup_charge_enable_out(backup_charge_enable_out),
    .fast_charge_enable_out(fast_charge_enable_out)
);

// >>> tb.sv
// tb: self-checking bench of the timekeeper over apb.
// assumes: crystal model ticks every clock, so one second is 32768 clocks.
`timescale 1ns/1ps
module tb;
    import rtk_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, xtal, full, pin, bsel, chg, fast;
    logic        supply_low = 1'b0;
    logic        pfi_low = 1'b0;
    int          failures = 0;
    int          num_checks = 0;

    always #20 clk = ~clk;

    rtk_xtal_cap_model u_rtk_xtal_cap_model (.sys_clk_in(clk),
        .reset_n_in(rst_n), .charge_in(chg), .xtal_tick_out(xtal),
        .backup_full_out(full));
    rtk_timekeeper u_rtk_timekeeper (.sys_clk_in(clk), .reset_n_in(rst_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .xtal_tick_in(xtal),
        .supply_low_in(supply_low), .backup_full_in(full),
        .pfi_low_in(pfi_low), .calib_or_powerfail_out(pin),
        .backup_select_out(bsel), .backup_charge_enable_out(chg),
        .fast_charge_enable_out(fast));

    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [4:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wreg(input logic [4:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, idx, wd, rd, er);
    endtask : wreg

    task automatic rchk(input logic [4:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, idx, 8'h00, rd, er);
        chk(rd, {24'h000000, exp});
    endtask : rchk

    task automatic t_reset_values;
        logic [31:0] rd;
        logic        er;
        rchk(IDX_CTRL, 8'h00);
        rchk(IDX_CALIB, CALIB_RESET);
        rchk(IDX_COMP, COMP_RESET);
        for (int i = 0; i < NUM_TIME; i++) begin
            rchk(IDX_SEC + 5'(i), TIME_RESET[8*i +: 8]);
        end
        chk(32'(pin), 32'h1);
        apb(1'b1, 5'h0A, 8'h5A, rd, er);
        chk(32'(er), 32'h1);
        apb(1'b0, 5'h09, 8'h00, rd, er);
        chk(rd, APB_ZERO);
        chk(32'(er), 32'h1);
    endtask : t_reset_values

    task automatic t_calibration;
        int toggles;
        logic last;
        wreg(IDX_CALIB, 8'h21);
        rchk(IDX_CALIB, 8'h00);
        wreg(IDX_CTRL, 8'h04);
        wreg(IDX_CALIB, 8'h21);
        rchk(IDX_CALIB, 8'h21);
        toggles = 0;
        @(posedge clk);
        last = pin;
        repeat (256) begin
            @(posedge clk);
            if (pin !== last) toggles++;
            last = pin;
        end
        chk(toggles, 8);
        wreg(IDX_CTRL, 8'h00);
        wreg(IDX_CALIB, 8'h05);
        rchk(IDX_CALIB, 8'h21);
        pfi_low <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(pin), 32'h0);
        pfi_low <= 1'b0;
    endtask : t_calibration

    task automatic t_time;
        logic [7:0]  ld [7] = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02,
                                8'h23};
        logic [7:0]  ex [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03,
                                8'h23};
        logic [31:0] rd;
        logic        er;
        int          n;
        wreg(IDX_CTRL, 8'h02);
        // legal codes only, one second before a month end
        for (int i = 0; i < 7; i++) wreg(IDX_SEC + 5'(i), ld[i]);
        rchk(IDX_SEC, 8'h59);
        wreg(IDX_CTRL, 8'h00);
        n = 0;
        do begin
            apb(1'b0, IDX_SEC, 8'h00, rd, er);
            n++;
        end while (rd[7:0] !== 8'h00 && n < 12000);
        chk(32'(rd[7:0]), 32'h0);
        wreg(IDX_CTRL, 8'h01);
        for (int i = 0; i < 7; i++) rchk(IDX_SEC + 5'(i), ex[i]);
        repeat (33000) @(posedge clk);
        rchk(IDX_SEC, 8'h00);
        wreg(IDX_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        rchk(IDX_SEC, 8'h01);
    endtask : t_time

    task automatic t_charger;
        wreg(IDX_COMP, 8'h24);
        rchk(IDX_COMP, 8'h24);
        chk(32'({chg, fast}), 32'h3);
        repeat (30) @(posedge clk);
        chk(32'({chg, fast}), 32'h0);
        supply_low <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'(bsel), 32'h1);
        supply_low <= 1'b0;
        wreg(IDX_COMP, 8'h00);
    endtask : t_charger

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_values();
        t_calibration();
        t_time();
        t_charger();
        wrap_up();
    end
endmodule : tb
